// *** timer_prescaler_clock_flags.sv ***
// Shared timer prescaler, per-timer clock select and timer 0 interrupt flags
//
// Behaviour
// - Compare interrupt raised when compare flag, its enable and global enable are set.
// - Overflow flag sets on counter overflow, clears when its vector executes.
// - Writing one to the overflow flag clears it.
// - Overflow interrupt only while global enable, overflow enable and flag are one.
// - In phase-correct PWM the overflow flag sets at the bottom turnaround.
// - Compare flag sets on counter match, clears when its vector executes.
// - Writing one to the compare flag clears it.
// - Compare interrupt only while global enable, compare enable and flag are set.
// - One shared prescaler; each timer has its own clock select.
// - Clock select one ticks the timer every system clock.
// - Prescaler taps divide the system clock by 8, 64, 256, 1024.
// - Prescaler runs freely; first prescaled tick comes 1 to N+1 cycles later.
// - Pin sampled every clock; tick per rising edge at 7, falling at 6.
// - Sampling stages clock on the rising edge of the system clock.
// - Timer tick follows a pin edge by about three system clocks.
// - External pin ticks bypass the prescaler entirely.
// - Prescaler reset bit resets prescaler, self-clears, zero ignored, reads zero.
// - Clock select zero gives no ticks; timer stays stopped.
// - Overflow enable with global enable allows the overflow interrupt.
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/1ps

module timer_prescaler_clock_flags
  import timer_clock_pkg::*;
#(
  parameter int PRESCALER_WIDTH = PRESCALER_WIDTH_DEFAULT
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  // External count pins, asynchronous
  input wire logic ext_count_pin_a,
  input wire logic ext_count_pin_b,
  // Timer 0 counter events, same clock
  input wire logic counter_max_t0,
  input wire logic counter_bottom_t0,
  input wire logic phase_correct_t0,
  input wire logic compare_match_t0,
  // Core interrupt side
  input wire logic global_irq_enable,
  input wire logic ovf_vector_ack_t0,
  input wire logic cmp_vector_ack_t0,
  output logic ovf_irq_t0,
  output logic cmp_irq_t0,
  // Timer clock enables
  output logic timer_tick_t0,
  output logic timer_tick_t1
);

  // Taps above the counter width could never fire
  if (PRESCALER_WIDTH < TAP_DIV1024_LOG2) begin : g_width_check
    $error("PRESCALER_WIDTH too small for the divide by 1024 tap");
  end

  // Register state
  logic [7:0] timer_interrupt_mask;
  logic cmp_flag_t0;
  logic ovf_flag_t0;
  logic [2:0] clock_select_field [TIMER_COUNT];
  logic [PRESCALER_WIDTH-1:0] prescaler_count;

  // Decoded accesses
  logic wr_mask;
  logic wr_flags;
  logic wr_special;
  logic wr_clock_select;

  always_comb begin
    wr_mask = 1'b0;
    wr_flags = 1'b0;
    wr_special = 1'b0;
    wr_clock_select = 1'b0;
    if (reg_write && reg_addr == ADDR_TIMER_INTERRUPT_MASK) begin
      wr_mask = 1'b1;
    end else if (reg_write && reg_addr == ADDR_TIMER_INTERRUPT_FLAGS) begin
      wr_flags = 1'b1;
    end else if (reg_write && reg_addr == ADDR_SPECIAL_FUNCTION_CONTROL) begin
      wr_special = 1'b1;
    end else if (reg_write && reg_addr == ADDR_CLOCK_SELECT) begin
      wr_clock_select = 1'b1;
    end
  end

  // Prescaler reset acts in the write cycle itself, so the strobe never needs storage
  logic prescaler_reset_strobe;

  assign prescaler_reset_strobe = wr_special && reg_wdata[PRESCALER_RESET_STROBE_BIT];

  // Interrupt mask register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_interrupt_mask <= TIMER_INTERRUPT_MASK_RESET;
    end else if (wr_mask) begin
      timer_interrupt_mask <= reg_wdata;
    end
  end

  // Clock select per timer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clock_select_field[0] <= CLOCK_SELECT_RESET;
      clock_select_field[1] <= CLOCK_SELECT_RESET;
    end else if (wr_clock_select) begin
      clock_select_field[0] <= reg_wdata[CLOCK_SELECT_T0_LSB +: 3];
      clock_select_field[1] <= reg_wdata[CLOCK_SELECT_T1_LSB +: 3];
    end
  end

  // Free-running prescaler, cleared only by rst_n and the reset strobe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prescaler_count <= '0;
    end else if (prescaler_reset_strobe) begin
      prescaler_count <= '0;
    end else begin
      prescaler_count <= prescaler_count + 1'b1;
    end
  end

  // Tap pulses, one cycle each time the low bits roll over
  logic tap_div8;
  logic tap_div64;
  logic tap_div256;
  logic tap_div1024;

  assign tap_div8 = &prescaler_count[TAP_DIV8_LOG2-1:0];
  assign tap_div64 = &prescaler_count[TAP_DIV64_LOG2-1:0];
  assign tap_div256 = &prescaler_count[TAP_DIV256_LOG2-1:0];
  assign tap_div1024 = &prescaler_count[TAP_DIV1024_LOG2-1:0];

  // Pin sampling and edge detection per timer
  logic [TIMER_COUNT-1:0] pin_raw;
  logic [TIMER_COUNT-1:0] pin_meta;
  logic [TIMER_COUNT-1:0] pin_sync;
  logic [TIMER_COUNT-1:0] pin_prev;
  logic [TIMER_COUNT-1:0] next_tick;
  logic [TIMER_COUNT-1:0] tick;

  assign pin_raw = {ext_count_pin_b, ext_count_pin_a};

  // Flops stand in for the latch plus register; delay stays near three cycles
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= '0;
      pin_sync <= '0;
      pin_prev <= '0;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  for (genvar t = 0; t < TIMER_COUNT; t++) begin : g_timer_clock
    always_comb begin
      next_tick[t] = 1'b0;
      case (clock_select_field[t])
        CS_STOPPED: next_tick[t] = 1'b0;
        CS_DIRECT: next_tick[t] = 1'b1;
        CS_DIV8: next_tick[t] = tap_div8;
        CS_DIV64: next_tick[t] = tap_div64;
        CS_DIV256: next_tick[t] = tap_div256;
        CS_DIV1024: next_tick[t] = tap_div1024;
        CS_EXT_FALL: next_tick[t] = pin_prev[t] && !pin_sync[t];
        CS_EXT_RISE: next_tick[t] = pin_sync[t] && !pin_prev[t];
        default: next_tick[t] = 1'b0;
      endcase
    end

    // Registered tick; the counter updates on the following edge
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        tick[t] <= 1'b0;
      end else begin
        tick[t] <= next_tick[t];
      end
    end
  end

  assign timer_tick_t0 = tick[0];
  assign timer_tick_t1 = tick[1];

  // Overflow event source depends on the counting mode
  logic ovf_event_t0;

  assign ovf_event_t0 = phase_correct_t0 ? counter_bottom_t0 : counter_max_t0;

  // Overflow flag: set wins over either kind of clear
  logic ovf_clear_t0;

  assign ovf_clear_t0 = ovf_vector_ack_t0
                     || (wr_flags && reg_wdata[OVF_FLAG_T0_BIT]);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_flag_t0 <= TIMER_INTERRUPT_FLAGS_RESET[OVF_FLAG_T0_BIT];
    end else if (ovf_event_t0) begin
      ovf_flag_t0 <= 1'b1;
    end else if (ovf_clear_t0) begin
      ovf_flag_t0 <= 1'b0;
    end
  end

  // Compare flag, same priority scheme
  logic cmp_clear_t0;

  assign cmp_clear_t0 = cmp_vector_ack_t0
                     || (wr_flags && reg_wdata[CMP_FLAG_T0_BIT]);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_flag_t0 <= TIMER_INTERRUPT_FLAGS_RESET[CMP_FLAG_T0_BIT];
    end else if (compare_match_t0) begin
      cmp_flag_t0 <= 1'b1;
    end else if (cmp_clear_t0) begin
      cmp_flag_t0 <= 1'b0;
    end
  end

  // Interrupt requests, registered from the current flag and enables
  logic ovf_irq_enable_t0;
  logic cmp_irq_enable_t0;

  assign ovf_irq_enable_t0 = timer_interrupt_mask[OVF_IRQ_ENABLE_T0_BIT];
  assign cmp_irq_enable_t0 = timer_interrupt_mask[CMP_IRQ_ENABLE_T0_BIT];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_irq_t0 <= 1'b0;
    end else begin
      ovf_irq_t0 <= global_irq_enable && ovf_irq_enable_t0 && ovf_flag_t0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_irq_t0 <= 1'b0;
    end else begin
      cmp_irq_t0 <= global_irq_enable && cmp_irq_enable_t0 && cmp_flag_t0;
    end
  end

  // Read data stands only in the cycle after the read strobe
  logic [7:0] next_rdata;

  always_comb begin
    next_rdata = READ_ZERO;
    if (reg_addr == ADDR_TIMER_INTERRUPT_MASK) begin
      next_rdata = timer_interrupt_mask;
    end else if (reg_addr == ADDR_TIMER_INTERRUPT_FLAGS) begin
      next_rdata[OVF_FLAG_T0_BIT] = ovf_flag_t0;
      next_rdata[CMP_FLAG_T0_BIT] = cmp_flag_t0;
    end else if (reg_addr == ADDR_SPECIAL_FUNCTION_CONTROL) begin
      next_rdata = READ_ZERO;
    end else if (reg_addr == ADDR_CLOCK_SELECT) begin
      next_rdata[CLOCK_SELECT_T0_LSB +: 3] = clock_select_field[0];
      next_rdata[CLOCK_SELECT_T1_LSB +: 3] = clock_select_field[1];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= READ_ZERO;
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= READ_ZERO;
    end
  end

endmodule : timer_prescaler_clock_flags

// *** timer_clock_pkg.sv ***
// Constants for the shared timer prescaler, clock select and timer 0 flags
package timer_clock_pkg;

  // Register indices on the plain register port
  localparam logic [3:0] ADDR_TIMER_INTERRUPT_MASK = 4'h0;
  localparam logic [3:0] ADDR_TIMER_INTERRUPT_FLAGS = 4'h1;
  localparam logic [3:0] ADDR_SPECIAL_FUNCTION_CONTROL = 4'h2;
  localparam logic [3:0] ADDR_CLOCK_SELECT = 4'h3;

  // Field positions
  localparam int CMP_IRQ_ENABLE_T0_BIT = 0;
  localparam int OVF_IRQ_ENABLE_T0_BIT = 1;
  localparam int CMP_FLAG_T0_BIT = 0;
  localparam int OVF_FLAG_T0_BIT = 1;
  localparam int PRESCALER_RESET_STROBE_BIT = 0;
  localparam int CLOCK_SELECT_T0_LSB = 0;
  localparam int CLOCK_SELECT_T1_LSB = 4;

  // Values after reset
  localparam logic [7:0] TIMER_INTERRUPT_MASK_RESET = 8'h00;
  localparam logic [7:0] TIMER_INTERRUPT_FLAGS_RESET = 8'h00;
  localparam logic [2:0] CLOCK_SELECT_RESET = 3'h0;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // Clock select codes
  localparam logic [2:0] CS_STOPPED = 3'h0;
  localparam logic [2:0] CS_DIRECT = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // Prescaler tap positions as log2 of the divisor
  localparam int TAP_DIV8_LOG2 = 3;
  localparam int TAP_DIV64_LOG2 = 6;
  localparam int TAP_DIV256_LOG2 = 8;
  localparam int TAP_DIV1024_LOG2 = 10;
  localparam int PRESCALER_WIDTH_DEFAULT = 10;
  localparam int TIMER_COUNT = 2;

endpackage : timer_clock_pkg

// *** timer_clock_props.sv ***
// Checker on the timer clock and flag ports
`timescale 1ns/1ps
module timer_clock_props
  import timer_clock_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  // Events, interrupts, ticks
  input wire logic ext_count_pin_a,
  input wire logic compare_match_t0,
  input wire logic global_irq_enable,
  input wire logic cmp_vector_ack_t0,
  input wire logic ovf_irq_t0,
  input wire logic cmp_irq_t0,
  input wire logic timer_tick_t0
);
  logic [2:0] cs;
  logic psr;
  // Shadow select, taken at the same edge as the design
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs <= CLOCK_SELECT_RESET;
    end else if (reg_write && reg_addr == ADDR_CLOCK_SELECT) begin
      cs <= reg_wdata[CLOCK_SELECT_T0_LSB +: 3];
    end
  end
  assign psr = reg_write && reg_addr == ADDR_SPECIAL_FUNCTION_CONTROL && reg_wdata[0];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_cmp_needs_global: assert property (cmp_irq_t0 |-> $past(global_irq_enable))
    else $error("cmp irq without global");
  a_ovf_needs_global: assert property (ovf_irq_t0 |-> $past(global_irq_enable))
    else $error("ovf irq without global");
  a_cmp_ack_drop: assert property ((cmp_vector_ack_t0 && !compare_match_t0) ##1
    !compare_match_t0 |=> !cmp_irq_t0)
    else $error("cmp irq after ack");
  a_stopped_no_tick: assert property (cs == CS_STOPPED && $past(cs) == CS_STOPPED
    |-> !timer_tick_t0)
    else $error("tick while stopped");
  a_direct_every_cycle: assert property (cs == CS_DIRECT && $past(cs) == CS_DIRECT
    |-> timer_tick_t0)
    else $error("direct tick missing");
  a_ext_rise_tick: assert property ($rose(ext_count_pin_a) && cs == CS_EXT_RISE
    && $past(cs) == CS_EXT_RISE |-> ##3 timer_tick_t0)
    else $error("pin edge tick missing");
  a_psr_div8_phase: assert property (psr && cs == CS_DIV8 && $past(cs) == CS_DIV8
    |-> ##2 !timer_tick_t0 [*7] ##1 timer_tick_t0)
    else $error("div8 phase after reset");
  a_rdata_idle_zero: assert property (!$past(reg_read) |-> reg_rdata == READ_ZERO)
    else $error("read data outside slot");
endmodule : timer_clock_props

// *** count_pin_source.sv ***
// External count clock source driving both count pins
`timescale 1ns/1ps
module count_pin_source (
  // Clock and control
  input wire logic sys_clk,
  input wire logic run,
  input wire logic [3:0] half,
  // Count pins
  output logic pin_a,
  output logic pin_b
);
  logic [3:0] left = 4'h0;
  initial pin_a = 1'b0;
  initial pin_b = 1'b1;
  // Half periods of three or more clocks; a started period always ends with pin_a low and pin_b high
  always @(posedge sys_clk) begin
    if (left != 4'h0) begin
      left <= left - 4'h1;
    end else if (run || pin_a) begin
      pin_a <= ~pin_a;
      pin_b <= ~pin_b;
      left <= half - 4'h1;
    end
  end
endmodule : count_pin_source

// *** timer_prescaler_clock_flags_bench.sv ***
// Self-checking bench for the timer clock and flag block
`timescale 1ns/1ps
module timer_prescaler_clock_flags_bench import timer_clock_pkg::*;;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [4:0] evs = 5'h00;
  logic phase = 1'b0;
  logic glob = 1'b0;
  logic run = 1'b0;
  logic [3:0] half = 4'h3;
  logic pa_q = 1'b0;
  logic [7:0] reg_rdata, r;
  logic pin_a, pin_b, ovf_irq, cmp_irq, tick0, tick1;
  logic [2:0] c0, c1;
  int n_fail = 0, cmp_count = 0, cyc = 0, n_t0 = 0, n_t1 = 0, n_rise = 0, s0, s1, sr;
  initial forever #10 sys_clk = ~sys_clk;
  timer_prescaler_clock_flags u_timer_prescaler_clock_flags (.sys_clk(sys_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .ext_count_pin_a(pin_a), .ext_count_pin_b(pin_b),
    .counter_max_t0(evs[0]), .counter_bottom_t0(evs[1]), .phase_correct_t0(phase),
    .compare_match_t0(evs[2]), .global_irq_enable(glob), .ovf_vector_ack_t0(evs[3]),
    .cmp_vector_ack_t0(evs[4]), .ovf_irq_t0(ovf_irq), .cmp_irq_t0(cmp_irq),
    .timer_tick_t0(tick0), .timer_tick_t1(tick1));
  count_pin_source u_count_pin_source (.sys_clk(sys_clk), .run(run), .half(half),
    .pin_a(pin_a), .pin_b(pin_b));
  always @(posedge sys_clk) begin
    pa_q <= pin_a;
    n_rise <= n_rise + int'(pin_a && !pa_q);
    n_t0 <= n_t0 + int'(tick0 === 1'b1);
    n_t1 <= n_t1 + int'(tick1 === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end
  function automatic int exp_ticks(input logic [2:0] cs);
    case (cs)
      CS_DIRECT: return 1024;
      CS_DIV8: return 1024 >> TAP_DIV8_LOG2;
      CS_DIV64: return 1024 >> TAP_DIV64_LOG2;
      CS_DIV256: return 1024 >> TAP_DIV256_LOG2;
      CS_DIV1024: return 1024 >> TAP_DIV1024_LOG2;
      default: return 0;
    endcase
  endfunction : exp_ticks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1 chk(16'(reg_rdata), 16'(exp));
  endtask : rd
  task automatic ev(input int i);
    @(posedge sys_clk);
    evs[i] <= 1'b1;
    @(posedge sys_clk);
    evs <= 5'h00;
    repeat (2) @(posedge sys_clk);
  endtask : ev
  task automatic final_report();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  initial begin
    void'($urandom(32'hFF0F));
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(ADDR_TIMER_INTERRUPT_MASK, TIMER_INTERRUPT_MASK_RESET);
    rd(ADDR_TIMER_INTERRUPT_FLAGS, TIMER_INTERRUPT_FLAGS_RESET);
    rd(ADDR_CLOCK_SELECT, 8'h00);
    r = 8'($urandom);
    wr(ADDR_TIMER_INTERRUPT_MASK, r);
    wr(4'hF, ~r);
    rd(4'hF, READ_ZERO);
    rd(ADDR_TIMER_INTERRUPT_MASK, r);
    $display("test registers done");
    ev(2);
    rd(ADDR_TIMER_INTERRUPT_FLAGS, 8'h01);
    wr(ADDR_TIMER_INTERRUPT_FLAGS, 8'hFC);
    rd(ADDR_TIMER_INTERRUPT_FLAGS, 8'h01);
    wr(ADDR_TIMER_INTERRUPT_MASK, 8'h03);
    glob <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 chk(16'(cmp_irq), 16'h1);
    chk(16'(ovf_irq), 16'h0);
    wr(ADDR_TIMER_INTERRUPT_FLAGS, 8'h01);
    rd(ADDR_TIMER_INTERRUPT_FLAGS, 8'h00);
    ev(0);
    #1 chk(16'(ovf_irq), 16'h1);
    ev(3);
    rd(ADDR_TIMER_INTERRUPT_FLAGS, 8'h00);
    phase <= 1'b1;
    ev(0);
    rd(ADDR_TIMER_INTERRUPT_FLAGS, 8'h00);
    glob <= 1'b0;
    ev(1);
    rd(ADDR_TIMER_INTERRUPT_FLAGS, 8'h02);
    chk(16'(ovf_irq), 16'h0);
    wr(ADDR_TIMER_INTERRUPT_FLAGS, 8'h02);
    rd(ADDR_TIMER_INTERRUPT_FLAGS, 8'h00);
    ev(2);
    ev(4);
    rd(ADDR_TIMER_INTERRUPT_FLAGS, 8'h00);
    $display("test flags done");
    for (int k = 0; k < 6; k++) begin
      c0 = 3'(k);
      c1 = 3'($urandom_range(5));
      wr(ADDR_CLOCK_SELECT, {1'b0, c1, 1'b0, c0});
      wr(ADDR_SPECIAL_FUNCTION_CONTROL, 8'($urandom) | 8'h01);
      rd(ADDR_SPECIAL_FUNCTION_CONTROL, READ_ZERO);
      s0 = n_t0;
      s1 = n_t1;
      repeat (1024) @(posedge sys_clk);
      // Let the last edge's count settle so the window holds exactly 1024 samples
      #1 chk(16'(n_t0 - s0), 16'(exp_ticks(c0)));
      chk(16'(n_t1 - s1), 16'(exp_ticks(c1)));
    end
    $display("test prescaler done");
    // Select changed only while both pins idle
    wr(ADDR_CLOCK_SELECT, {1'b0, CS_EXT_FALL, 1'b0, CS_EXT_RISE});
    repeat (4) @(posedge sys_clk);
    s0 = n_t0;
    s1 = n_t1;
    sr = n_rise;
    half <= 4'(3 + $urandom_range(3));
    run <= 1'b1;
    repeat (300) @(posedge sys_clk);
    run <= 1'b0;
    repeat (40) @(posedge sys_clk);
    chk(16'(n_t0 - s0), 16'(n_rise - sr));
    chk(16'(n_t1 - s1), 16'(n_rise - sr));
    wr(ADDR_CLOCK_SELECT, 8'h00);
    $display("test external pins done");
    final_report();
  end
endmodule : timer_prescaler_clock_flags_bench
bind timer_prescaler_clock_flags timer_clock_props u_timer_clock_props (.sys_clk(sys_clk),
  .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .ext_count_pin_a(ext_count_pin_a),
  .compare_match_t0(compare_match_t0), .global_irq_enable(global_irq_enable),
  .cmp_vector_ack_t0(cmp_vector_ack_t0), .ovf_irq_t0(ovf_irq_t0), .cmp_irq_t0(cmp_irq_t0),
  .timer_tick_t0(timer_tick_t0));
